// file: usart_status_and_control_pkg.sv
// Register map, field positions and state types of the serial status and control block
package usart_status_and_control_pkg;

   // Register indexes; the byte address is four times the index
   localparam logic [7:0] LINE_STATUS_FLAGS_IDX = 8'h04;
   localparam logic [7:0] INTERRUPT_AND_LINE_CONTROL_IDX = 8'h05;
   localparam logic [7:0] RECEIVER_TRANSMITTER_CONTROL_IDX = 8'h06;
   localparam logic [7:0] FRAME_FORMAT_CONTROL_IDX = 8'h07;
   localparam int ADDR_LSB = 2;
   localparam int IDX_WIDTH = 8;

   // Reset values
   localparam logic [7:0] LINE_STATUS_FLAGS_RST = 8'h00;
   localparam logic [7:0] INTERRUPT_AND_LINE_CONTROL_RST = 8'h00;
   localparam logic [7:0] RECEIVER_TRANSMITTER_CONTROL_RST = 8'h00;
   localparam logic [7:0] FRAME_FORMAT_CONTROL_RST = 8'h03;

   // Status bit positions
   localparam int RX_COMPLETE_FLAG_BIT = 7;
   localparam int TX_COMPLETE_FLAG_BIT = 6;
   localparam int TX_EMPTY_FLAG_BIT = 5;
   localparam int RX_START_FLAG_BIT = 4;
   localparam int SYNC_FIELD_ERROR_FLAG_BIT = 3;
   localparam int BREAK_SEEN_FLAG_BIT = 1;
   localparam int WAIT_BREAK_ENABLE_BIT = 0;

   // Interrupt and line control bit positions
   localparam int RX_COMPLETE_IRQ_EN_BIT = 7;
   localparam int TX_COMPLETE_IRQ_EN_BIT = 6;
   localparam int TX_EMPTY_IRQ_EN_BIT = 5;
   localparam int RX_START_IRQ_EN_BIT = 4;
   localparam int LOOPBACK_ENABLE_BIT = 3;
   localparam int AUTOBAUD_ERROR_IRQ_EN_BIT = 2;
   localparam int LINE_DRIVER_MODE_HI = 1;
   localparam int LINE_DRIVER_MODE_LO = 0;
   localparam int DIRECTION_CTRL_BIT = 0;
   localparam int PIN_TURN_CTRL_BIT = 1;

   // Receiver and transmitter control bit positions
   localparam int RECEIVER_ON_BIT = 7;
   localparam int TRANSMITTER_ON_BIT = 6;
   localparam int FRAME_START_DETECT_EN_BIT = 4;
   localparam int OPEN_DRAIN_ENABLE_BIT = 3;
   localparam int RECEIVER_SPEED_MODE_HI = 2;
   localparam int RECEIVER_SPEED_MODE_LO = 1;
   localparam int MULTIDROP_MODE_EN_BIT = 0;
   localparam logic [7:0] RECEIVER_TRANSMITTER_CONTROL_MASK = 8'hdf;

   // Frame format control bit positions
   localparam int COMM_MODE_SELECT_HI = 7;
   localparam int COMM_MODE_SELECT_LO = 6;

   localparam logic [7:0] LIN_SYNC_CHAR = 8'h55;

   typedef enum logic [1:0] {
      NORMAL_SPEED = 2'h0,
      DOUBLE_SPEED = 2'h1,
      GENERIC_AUTOBAUD = 2'h2,
      LIN_AUTOBAUD = 2'h3
   } receiver_speed_mode_type;

   typedef enum logic [1:0] {
      ASYNC_MODE = 2'h0,
      SYNC_MODE = 2'h1,
      INFRARED_MODE = 2'h2,
      HOST_SPI_MODE = 2'h3
   } comm_mode_select_type;

   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_LEAD = 2'b01,
      TX_ACTIVE = 2'b10
   } tx_phase_type;

   // Flags that hardware sets and software clears by writing one
   typedef struct packed {
      logic tx_complete_flag;
      logic rx_start_flag;
      logic sync_field_error_flag;
      logic break_seen_flag;
   } sticky_flags_type;

   // Events reported by the auto-baud detector
   typedef struct packed {
      logic sync_length_bad;
      logic sync_char_valid;
      logic [7:0] sync_char;
      logic break_sync_ok;
   } autobaud_events_type;

   typedef struct packed {
      sticky_flags_type flags;
      logic wait_break_enable;
      logic [7:0] line_ctrl;
      logic [7:0] rxtx_ctrl;
      logic [7:0] format_ctrl;
      logic wr_pending;
      logic [IDX_WIDTH-1:0] wr_idx;
      logic [31:0] rdata;
      tx_phase_type tx_phase;
      logic [2:0] rxd_sync;
      logic rxd_filt;
      logic rx_line;
   } state_type;

endpackage

// file: usart_status_and_control.sv
// Status flags, control registers and line steering of a serial transceiver
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps

// Overview of operation
// - Receive-complete flag follows unread receive data
// - Transmit-complete set when idle; one clears
// - Data-empty flag follows empty transmit registers
// - Receive-start flag on start bit in standby
// - Auto-baud sync length error sets error flag
// - LIN auto-baud: sync not 0x55 flags error
// - Break flag set on break; data or one clears
// - Status bit zero is write-only wait-for-break
// - Four interrupt requests gated by their enables
// - Auto-baud error interrupt gated by its enable
// - Loop-back feeds the shifter's transmit bit to receiver
// - Direction output leads transmission by one cycle
// - Transmit pin output one cycle before start
// - Receiver enable bit
// - Transmitter enable bit
// - Start-of-frame detection enable bit
// - Open-drain line enable bit
// - Receiver mode field decode
// - Multiprocessor mode enable bit
// - Communication mode field decode
module usart_status_and_control
   import usart_status_and_control_pkg::*;
(
   input wire logic ref_clk_i, // 100 MHz clock
   input wire logic rst_n_i, // Synchronous reset, active low
   input wire logic hsel_i, // AHB select
   input wire logic [31:0] haddr_i, // AHB address
   input wire logic [1:0] htrans_i, // AHB transfer type
   input wire logic hwrite_i, // AHB write
   input wire logic [2:0] hsize_i, // AHB size
   input wire logic [31:0] hwdata_i, // AHB write data
   input wire logic hready_i, // AHB bus ready
   output logic [31:0] hrdata_o, // AHB read data
   output logic hreadyout_o, // AHB slave ready
   output logic hresp_o, // AHB response
   input wire logic rx_buffer_unread_i, // Receive buffer holds unread data
   input wire logic tx_buffer_empty_i, // Transmit data registers empty
   input wire logic tx_start_i, // Shifter has a frame to start
   input wire logic tx_done_i, // Frame has left the shift register
   input wire logic txd_bit_i, // Serial bit from the shifter
   input wire logic standby_i, // Chip is in standby sleep
   input wire logic start_bit_i, // Valid start bit seen
   input wire logic rx_data_received_i, // New data received
   input wire autobaud_events_type autobaud_i, // Auto-baud detector events
   input wire logic rxd_pin_i, // Receive pin, asynchronous
   output logic rx_line_o, // Bit stream into the receiver
   output logic tx_go_o, // Start the shifter
   output logic txd_o, // Transmit pin output
   output logic txd_oe_o, // Transmit pin output enable
   output logic direction_out_o, // Line driver direction
   output logic rx_complete_irq_o, // Receive complete request
   output logic tx_complete_irq_o, // Transmit complete request
   output logic tx_empty_irq_o, // Data register empty request
   output logic rx_start_irq_o, // Receive start request
   output logic autobaud_error_irq_o, // Auto-baud error request
   output logic receiver_on_o, // Receiver enabled
   output logic transmitter_on_o, // Transmitter enabled
   output logic frame_start_detect_en_o, // Start-of-frame detection enabled
   output logic open_drain_enable_o, // Open-drain line
   output logic multidrop_mode_en_o, // Multiprocessor mode
   output logic wait_break_enable_o, // Wait for break
   output logic loopback_enable_o, // Loop-back active
   output logic double_speed_o, // Double-speed receiver
   output logic generic_autobaud_o, // Generic auto-baud
   output logic lin_autobaud_o, // LIN auto-baud
   output logic async_mode_o, // Asynchronous mode
   output logic sync_mode_o, // Synchronous mode
   output logic infrared_mode_o, // Infrared mode
   output logic host_spi_mode_o // Host SPI mode
);

   state_type s;
   state_type next_s;

   logic addr_take;
   logic [IDX_WIDTH-1:0] addr_idx;
   logic wr_status;
   logic [7:0] wdata;
   logic [7:0] status_view;
   receiver_speed_mode_type rx_mode;
   comm_mode_select_type comm_mode;
   logic autobaud_on;
   logic lin_auto;
   logic host_spi;
   logic tx_running;

   assign addr_take = hsel_i && htrans_i[1] && hready_i;
   assign addr_idx = haddr_i[ADDR_LSB +: IDX_WIDTH];
   assign wdata = hwdata_i[7:0];
   assign wr_status = s.wr_pending && (s.wr_idx == LINE_STATUS_FLAGS_IDX);

   assign rx_mode = receiver_speed_mode_type'(
      s.rxtx_ctrl[RECEIVER_SPEED_MODE_HI:RECEIVER_SPEED_MODE_LO]);
   assign comm_mode = comm_mode_select_type'(
      s.format_ctrl[COMM_MODE_SELECT_HI:COMM_MODE_SELECT_LO]);
   assign autobaud_on = (rx_mode == GENERIC_AUTOBAUD) || (rx_mode == LIN_AUTOBAUD);
   assign lin_auto = (rx_mode == LIN_AUTOBAUD);
   assign host_spi = (comm_mode == HOST_SPI_MODE);
   assign tx_running = (s.tx_phase != TX_IDLE);

   always_comb begin
      next_s = s;

      // Writes land one cycle after the address phase
      if (addr_take) begin
         next_s.wr_pending = hwrite_i;
         next_s.wr_idx = addr_idx;
      end else begin
         next_s.wr_pending = 1'b0;
      end

      if (s.wr_pending) begin
         if (s.wr_idx == INTERRUPT_AND_LINE_CONTROL_IDX) begin
            next_s.line_ctrl = wdata;
         end else if (s.wr_idx == RECEIVER_TRANSMITTER_CONTROL_IDX) begin
            next_s.rxtx_ctrl = wdata & RECEIVER_TRANSMITTER_CONTROL_MASK;
         end else if (s.wr_idx == FRAME_FORMAT_CONTROL_IDX) begin
            next_s.format_ctrl = wdata;
         end else if (s.wr_idx == LINE_STATUS_FLAGS_IDX) begin
            next_s.wait_break_enable = wdata[WAIT_BREAK_ENABLE_BIT];
         end
      end

      // Clear by writing one; a new event in the same cycle wins
      next_s.flags.tx_complete_flag = (tx_done_i && tx_buffer_empty_i)
         || (s.flags.tx_complete_flag
         && !(wr_status && wdata[TX_COMPLETE_FLAG_BIT]));
      next_s.flags.rx_start_flag = (s.rxtx_ctrl[FRAME_START_DETECT_EN_BIT]
         && standby_i && start_bit_i && !host_spi)
         || (s.flags.rx_start_flag
         && !(wr_status && wdata[RX_START_FLAG_BIT]));
      next_s.flags.sync_field_error_flag = (autobaud_on && autobaud_i.sync_length_bad)
         || (lin_auto && autobaud_i.sync_char_valid
         && (autobaud_i.sync_char != LIN_SYNC_CHAR))
         || (s.flags.sync_field_error_flag
         && !(wr_status && wdata[SYNC_FIELD_ERROR_FLAG_BIT]));
      // Break flag also drops on the next received data
      next_s.flags.break_seen_flag = (autobaud_on && autobaud_i.break_sync_ok)
         || (s.flags.break_seen_flag && !rx_data_received_i
         && !(wr_status && wdata[BREAK_SEEN_FLAG_BIT]));

      // Line direction leads the shifter by one clock
      case (s.tx_phase)
         TX_IDLE: begin
            if (tx_start_i && s.rxtx_ctrl[TRANSMITTER_ON_BIT]) begin
               next_s.tx_phase = TX_LEAD;
            end
         end
         TX_LEAD: begin
            next_s.tx_phase = TX_ACTIVE;
         end
         TX_ACTIVE: begin
            if (tx_done_i) begin
               next_s.tx_phase = TX_IDLE;
            end
         end
         default: begin
            next_s.tx_phase = TX_IDLE;
         end
      endcase

      // First stage feeds only the second; change taken once stages two and three agree
      next_s.rxd_sync = {s.rxd_sync[1:0], rxd_pin_i};
      if (s.rxd_sync[1] == s.rxd_sync[2]) begin
         next_s.rxd_filt = s.rxd_sync[2];
      end
      next_s.rx_line = s.line_ctrl[LOOPBACK_ENABLE_BIT] ? txd_bit_i : s.rxd_filt;

      // Status view in this process, so rdata forms no loop through next_s
      status_view = 8'h00;
      status_view[RX_COMPLETE_FLAG_BIT] = rx_buffer_unread_i;
      status_view[TX_COMPLETE_FLAG_BIT] = next_s.flags.tx_complete_flag;
      status_view[TX_EMPTY_FLAG_BIT] = tx_buffer_empty_i;
      status_view[RX_START_FLAG_BIT] = next_s.flags.rx_start_flag;
      status_view[SYNC_FIELD_ERROR_FLAG_BIT] = next_s.flags.sync_field_error_flag;
      status_view[BREAK_SEEN_FLAG_BIT] = next_s.flags.break_seen_flag;

      // Read data come from the values after any write landing now
      next_s.rdata = 32'h0000_0000;
      if (addr_take && !hwrite_i) begin
         if (addr_idx == LINE_STATUS_FLAGS_IDX) begin
            next_s.rdata[7:0] = status_view;
         end else if (addr_idx == INTERRUPT_AND_LINE_CONTROL_IDX) begin
            next_s.rdata[7:0] = next_s.line_ctrl;
         end else if (addr_idx == RECEIVER_TRANSMITTER_CONTROL_IDX) begin
            next_s.rdata[7:0] = next_s.rxtx_ctrl;
         end else if (addr_idx == FRAME_FORMAT_CONTROL_IDX) begin
            next_s.rdata[7:0] = next_s.format_ctrl;
         end
      end

      if (!rst_n_i) begin
         next_s.flags = '0;
         next_s.wait_break_enable = LINE_STATUS_FLAGS_RST[WAIT_BREAK_ENABLE_BIT];
         next_s.line_ctrl = INTERRUPT_AND_LINE_CONTROL_RST;
         next_s.rxtx_ctrl = RECEIVER_TRANSMITTER_CONTROL_RST;
         next_s.format_ctrl = FRAME_FORMAT_CONTROL_RST;
         next_s.wr_pending = 1'b0;
         next_s.wr_idx = '0;
         next_s.rdata = 32'h0000_0000;
         next_s.tx_phase = TX_IDLE;
         next_s.rxd_sync = 3'h7;
         next_s.rxd_filt = 1'b1;
         next_s.rx_line = 1'b1;
      end
   end

   // Write-only and reserved status bits read as zero
   always_ff @(posedge ref_clk_i) begin
      s <= next_s;
   end

   // Zero-wait slave, always OKAY
   assign hrdata_o = s.rdata;
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;

   assign rx_line_o = s.rx_line;
   assign tx_go_o = (s.tx_phase == TX_LEAD);
   assign direction_out_o = s.line_ctrl[DIRECTION_CTRL_BIT] && tx_running;

   // Open drain only ever pulls the line low
   always_comb begin
      logic drive;
      drive = s.line_ctrl[PIN_TURN_CTRL_BIT] ? tx_running
         : s.rxtx_ctrl[TRANSMITTER_ON_BIT];
      if (s.rxtx_ctrl[OPEN_DRAIN_ENABLE_BIT]) begin
         txd_o = 1'b0;
         txd_oe_o = drive && !txd_bit_i;
      end else begin
         txd_o = txd_bit_i;
         txd_oe_o = drive;
      end
   end

   assign rx_complete_irq_o = s.line_ctrl[RX_COMPLETE_IRQ_EN_BIT]
      && rx_buffer_unread_i;
   assign tx_complete_irq_o = s.line_ctrl[TX_COMPLETE_IRQ_EN_BIT]
      && s.flags.tx_complete_flag;
   assign tx_empty_irq_o = s.line_ctrl[TX_EMPTY_IRQ_EN_BIT] && tx_buffer_empty_i;
   assign rx_start_irq_o = s.line_ctrl[RX_START_IRQ_EN_BIT]
      && s.flags.rx_start_flag;
   assign autobaud_error_irq_o = s.line_ctrl[AUTOBAUD_ERROR_IRQ_EN_BIT]
      && s.flags.sync_field_error_flag;

   assign receiver_on_o = s.rxtx_ctrl[RECEIVER_ON_BIT];
   assign transmitter_on_o = s.rxtx_ctrl[TRANSMITTER_ON_BIT];
   assign frame_start_detect_en_o = s.rxtx_ctrl[FRAME_START_DETECT_EN_BIT];
   assign open_drain_enable_o = s.rxtx_ctrl[OPEN_DRAIN_ENABLE_BIT];
   assign multidrop_mode_en_o = s.rxtx_ctrl[MULTIDROP_MODE_EN_BIT];
   assign wait_break_enable_o = s.wait_break_enable;
   assign loopback_enable_o = s.line_ctrl[LOOPBACK_ENABLE_BIT];

   // Not forced to normal speed in async or infrared; software keeps it there
   assign double_speed_o = (rx_mode == DOUBLE_SPEED);
   assign generic_autobaud_o = (rx_mode == GENERIC_AUTOBAUD);
   assign lin_autobaud_o = lin_auto;
   assign async_mode_o = (comm_mode == ASYNC_MODE);
   assign sync_mode_o = (comm_mode == SYNC_MODE);
   assign infrared_mode_o = (comm_mode == INFRARED_MODE);
   assign host_spi_mode_o = host_spi;

endmodule

// file: usart_status_and_control_chk.sv
// Property checker for the serial status and control block
`timescale 1ns/1ps
module usart_status_and_control_chk
   import usart_status_and_control_pkg::*;
(
   input wire logic ref_clk_i, rst_n_i, hsel_i, hwrite_i, hready_i, // Clock, reset, bus
   input wire logic [1:0] htrans_i, // Transfer type
   input wire logic tx_start_i, tx_done_i, tx_buffer_empty_i, txd_bit_i, // Shifter side
   input wire logic rx_buffer_unread_i, standby_i, start_bit_i, // Receive side
   input wire autobaud_events_type autobaud_i, // Detector events
   input wire logic rx_line_o, tx_go_o, direction_out_o, loopback_enable_o, // Line steering
   input wire logic rx_complete_irq_o, tx_complete_irq_o, tx_empty_irq_o, // Requests
   input wire logic rx_start_irq_o, autobaud_error_irq_o, transmitter_on_o, // Requests
   input wire logic frame_start_detect_en_o, host_spi_mode_o, async_mode_o, // Modes
   input wire logic sync_mode_o, infrared_mode_o, double_speed_o, // Modes
   input wire logic generic_autobaud_o, lin_autobaud_o // Modes
);
   logic wr_dp;
   logic ab_err;
   // Write data phase: enables and clears land at its closing edge
   always_ff @(posedge ref_clk_i) begin
      wr_dp <= rst_n_i && hsel_i && htrans_i[1] && hready_i && hwrite_i;
   end
   assign ab_err = ((generic_autobaud_o || lin_autobaud_o) && autobaud_i.sync_length_bad)
      || (lin_autobaud_o && autobaud_i.sync_char_valid && autobaud_i.sync_char != 8'h55);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence lead_s;
      $rose(direction_out_o) && !$past(wr_dp);
   endsequence
   sequence done_s;
      direction_out_o && tx_done_i && !tx_go_o;
   endsequence
   tx_go_cause_a: assert property (
      tx_go_o |-> $past(tx_start_i && transmitter_on_o) ##1 !tx_go_o)
      else $error("shifter start without a taken request");
   dir_lead_a: assert property (lead_s |-> tx_go_o)
      else $error("direction rose without a leading start");
   dir_drop_a: assert property (done_s |=> !direction_out_o)
      else $error("direction held after frame end");
   loop_path_a: assert property (
      loopback_enable_o && $past(loopback_enable_o) |-> rx_line_o == $past(txd_bit_i))
      else $error("receiver not fed from transmit bit");
   rxc_irq_a: assert property (rx_complete_irq_o |-> rx_buffer_unread_i)
      else $error("receive request without unread data");
   dre_irq_a: assert property (tx_empty_irq_o |-> tx_buffer_empty_i)
      else $error("empty request with data buffered");
   txc_rise_a: assert property ($rose(tx_complete_irq_o) |->
      $past(wr_dp) || $past(tx_done_i && tx_buffer_empty_i))
      else $error("transmit complete without cause");
   rxs_rise_a: assert property ($rose(rx_start_irq_o) |-> $past(wr_dp) ||
      $past(start_bit_i && standby_i && frame_start_detect_en_o && !host_spi_mode_o))
      else $error("receive start without cause");
   abe_rise_a: assert property ($rose(autobaud_error_irq_o) |->
      $past(wr_dp) || $past(ab_err))
      else $error("auto-baud error without cause");
   speed_code_a: assert property (
      $onehot0({double_speed_o, generic_autobaud_o, lin_autobaud_o}))
      else $error("receiver mode decode not exclusive");
   comm_code_a: assert property (
      $onehot({async_mode_o, sync_mode_o, infrared_mode_o, host_spi_mode_o}))
      else $error("communication mode decode not one-hot");
endmodule

bind usart_status_and_control usart_status_and_control_chk chk (.*);

// file: serial_node.sv
// Remote serial node that sends one frame on the receive pin
`timescale 1ns/1ps
module serial_node (
   input wire logic clk_i, // Bench clock
   input wire logic go_i, // Send one frame
   input wire logic [7:0] data_i, // Frame payload
   output logic line_o // Serial line
);
   localparam int BIT_CYC = 8;
   logic [9:0] sh = 10'h3ff;
   int cnt = 0;
   int bits = 0;
   initial line_o = 1'b1;
   always @(posedge clk_i) begin
      if (bits == 0) begin
         line_o <= 1'b1; // Idle line rests at the pull-up level
         if (go_i) begin
            sh <= {1'b1, data_i, 1'b0};
            bits <= 10;
            cnt <= 0;
         end
      end else begin
         line_o <= sh[0];
         cnt <= cnt + 1;
         if (cnt == BIT_CYC - 1) begin
            sh <= sh >> 1;
            bits <= bits - 1;
            cnt <= 0;
         end
      end
   end
endmodule

// file: tb_top.sv
// Self-checking bench for the serial status and control block
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
   $display("BAD %s expected %h seen %h", n, e, a); end end
module tb_top
   import usart_status_and_control_pkg::*;
;
   logic ref_clk_i = 1'b0, rst_n_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0;
   logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o;
   logic [1:0] htrans_i = 2'h0;
   logic [2:0] hsize_i = 3'h2;
   logic rx_buffer_unread_i = 1'b0, tx_buffer_empty_i = 1'b1, tx_start_i = 1'b0;
   logic tx_done_i = 1'b0, txd_bit_i = 1'b1, standby_i = 1'b0, start_bit_i = 1'b0;
   logic rx_data_received_i = 1'b0, hready_i, rxd_pin_i, node_go = 1'b0;
   autobaud_events_type autobaud_i = '0;
   logic [7:0] node_byte = 8'h0, a, b, f, s, r, ch;
   logic [3:0] e4;
   logic [1:0] h;
   logic hreadyout_o, hresp_o, rx_line_o, tx_go_o, txd_o, txd_oe_o, direction_out_o;
   logic rx_complete_irq_o, tx_complete_irq_o, tx_empty_irq_o, rx_start_irq_o;
   logic autobaud_error_irq_o, receiver_on_o, transmitter_on_o, frame_start_detect_en_o;
   logic open_drain_enable_o, multidrop_mode_en_o, wait_break_enable_o, loopback_enable_o;
   logic double_speed_o, generic_autobaud_o, lin_autobaud_o, async_mode_o, sync_mode_o;
   logic infrared_mode_o, host_spi_mode_o, sb, last;
   logic txc = 1'b0, rxs = 1'b0, sfe = 1'b0, brk = 1'b0;
   int seed = 24663, miscompares = 0, checks_done = 0, cyc = 0, i, k, st;
   assign hready_i = hreadyout_o;
   usart_status_and_control DUT (.*);
   serial_node node (.clk_i(ref_clk_i), .go_i(node_go), .data_i(node_byte), .line_o(rxd_pin_i));
   always #5 ref_clk_i = ~ref_clk_i;
   task end_sim;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 6000) begin
         miscompares++;
         end_sim();
      end
   end
   function automatic logic [7:0] exp_st();
      return {rx_buffer_unread_i, txc, tx_buffer_empty_i, rxs, sfe, 1'b0, brk, 1'b0};
   endfunction
   // Sticky flags {txc, rxs, sfe, brk} that event k sets
   function automatic logic [3:0] sets(input int k, input logic [7:0] b, f, c, input logic sb, e);
      case (k)
         0: return {e, 3'b0};
         1: return {1'b0, b[4] && sb && f[7:6] != 2'h3, 2'b0};
         2: return {2'b0, b[2], 1'b0};
         3: return {2'b0, b[2:1] == 2'h3 && c != 8'h55, 1'b0};
         4: return {3'b0, b[2]};
         default: return 4'b0;
      endcase
   endfunction
   // Software keeps normal speed outside synchronous and host SPI
   function automatic logic [7:0] fixb(input logic [7:0] b, f);
      return f[6] ? b : {b[7:3], 2'b00, b[0]};
   endfunction
   task bus(input logic w, input logic [7:0] idx, d, output logic [7:0] q);
      hsel_i <= 1'b1;
      htrans_i <= 2'h2;
      hwrite_i <= w;
      haddr_i <= {22'h0, idx, 2'b00};
      @(posedge ref_clk_i);
      while (!hready_i) @(posedge ref_clk_i);
      hsel_i <= 1'b0;
      htrans_i <= 2'h0;
      hwdata_i <= {24'h0, d};
      @(posedge ref_clk_i);
      while (!hready_i) @(posedge ref_clk_i);
      q = hrdata_o[7:0];
   endtask
   task wr(input logic [7:0] idx, d);
      bus(1'b1, idx, d, r);
   endtask
   task rchk(input logic [7:0] idx, e);
      bus(1'b0, idx, 8'h0, r);
      `CHK("reg", e, r)
      `CHK("resp", 1'b0, hresp_o)
   endtask
   task ev(input int k);
      case (k)
         0: tx_done_i <= 1'b1;
         1: start_bit_i <= 1'b1;
         2: autobaud_i.sync_length_bad <= 1'b1;
         3: autobaud_i.sync_char_valid <= 1'b1;
         4: autobaud_i.break_sync_ok <= 1'b1;
         default: rx_data_received_i <= 1'b1;
      endcase
      @(posedge ref_clk_i);
      {tx_done_i, start_bit_i, rx_data_received_i} <= 3'b0;
      {autobaud_i.sync_length_bad, autobaud_i.sync_char_valid} <= 2'b0;
      autobaud_i.break_sync_ok <= 1'b0;
   endtask
   initial begin
      repeat (8) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      rchk(8'h04, 8'h20);
      rchk(8'h05, 8'h00);
      rchk(8'h06, 8'h00);
      rchk(8'h07, 8'h03);
      wr(8'h09, 8'hff);
      rchk(8'h09, 8'h00);
      for (i = 0; i < 16; i++) begin
         a = $random(seed);
         b = $random(seed);
         f = $random(seed);
         s = $random(seed);
         f[7:6] = i[1:0];
         b[2:1] = i[3:2];
         b = fixb(b, f);
         {rx_buffer_unread_i, tx_buffer_empty_i} <= s[7:6];
         wr(8'h05, a);
         wr(8'h06, b);
         wr(8'h07, f);
         wr(8'h04, s);
         rchk(8'h05, a);
         rchk(8'h06, b & 8'hdf);
         rchk(8'h07, f);
         rchk(8'h04, exp_st());
         `CHK("rx_on", b[7], receiver_on_o)
         `CHK("tx_on", b[6], transmitter_on_o)
         `CHK("sfd", b[4], frame_start_detect_en_o)
         `CHK("odm", b[3], open_drain_enable_o)
         `CHK("multidrop_mode_en", b[0], multidrop_mode_en_o)
         `CHK("wfb", s[0], wait_break_enable_o)
         `CHK("lbk", a[3], loopback_enable_o)
         e4 = 4'h1 << b[2:1];
         `CHK("speed", e4[3:1], {lin_autobaud_o, generic_autobaud_o, double_speed_o})
         e4 = 4'h1 << f[7:6];
         `CHK("comm", e4, {host_spi_mode_o, infrared_mode_o, sync_mode_o, async_mode_o})
         `CHK("irq_a", {a[7] & s[7], a[5] & s[6]}, {rx_complete_irq_o, tx_empty_irq_o})
      end
      wr(8'h05, 8'hf4);
      for (i = 0; i < 48; i++) begin
         f = $random(seed);
         b = $random(seed);
         b = fixb(b, f);
         s = $random(seed);
         ch = $random(seed);
         sb = s[2];
         k = {$random(seed)} % 6;
         if (ch[0])
            ch = 8'h55;
         tx_buffer_empty_i <= s[1];
         wr(8'h06, b);
         wr(8'h07, f);
         standby_i <= sb;
         autobaud_i.sync_char <= ch;
         ev(k);
         {txc, rxs, sfe, brk} = {txc, rxs, sfe, brk} | sets(k, b, f, ch, sb, s[1]);
         if (k == 5)
            brk = 1'b0;
         rchk(8'h04, exp_st());
         `CHK("irqs", {txc, rxs, sfe}, {tx_complete_irq_o, rx_start_irq_o, autobaud_error_irq_o})
         wr(8'h04, s);
         {txc, rxs, sfe, brk} = {txc, rxs, sfe, brk} & ~{s[6], s[4], s[3], s[1]};
         rchk(8'h04, exp_st());
      end
      wr(8'h05, 8'h03);
      wr(8'h06, 8'h40);
      @(posedge ref_clk_i);
      tx_start_i <= 1'b1;
      @(posedge ref_clk_i);
      tx_start_i <= 1'b0;
      @(posedge ref_clk_i);
      `CHK("lead", 3'h7, {tx_go_o, direction_out_o, txd_oe_o})
      @(posedge ref_clk_i);
      `CHK("active", 2'h1, {tx_go_o, direction_out_o})
      tx_done_i <= 1'b1;
      @(posedge ref_clk_i);
      tx_done_i <= 1'b0;
      @(posedge ref_clk_i);
      `CHK("idle", 2'h0, {direction_out_o, txd_oe_o})
      wr(8'h06, 8'h00);
      tx_start_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      `CHK("tx_off", 2'h0, {tx_go_o, direction_out_o})
      tx_start_i <= 1'b0;
      wr(8'h05, 8'h08);
      @(posedge ref_clk_i);
      h = 2'h0;
      // Loop-back path: receiver sees the shifter bit two samples later
      for (i = 0; i < 12; i++) begin
         @(posedge ref_clk_i);
         if (i > 1)
            `CHK("loop", h[1], rx_line_o)
         s = $random(seed);
         h = {h[0], s[0]};
         txd_bit_i <= s[0];
      end
      wr(8'h05, 8'h00);
      // Open drain only pulls low; push-pull follows the bit
      wr(8'h06, 8'h48);
      txd_bit_i <= 1'b0;
      @(posedge ref_clk_i);
      `CHK("od_low", 2'h1, {txd_o, txd_oe_o})
      txd_bit_i <= 1'b1;
      @(posedge ref_clk_i);
      `CHK("od_high", 2'h0, {txd_o, txd_oe_o})
      wr(8'h06, 8'h40);
      @(posedge ref_clk_i);
      `CHK("push_pull", 2'h3, {txd_o, txd_oe_o})
      node_byte <= $random(seed);
      node_go <= 1'b1;
      @(posedge ref_clk_i);
      node_go <= 1'b0;
      st = 0;
      last = 1'b1;
      // Pin path has a filter, so compare only once the line has settled
      for (i = 0; i < 100; i++) begin
         @(posedge ref_clk_i);
         st = (rxd_pin_i === last) ? st + 1 : 0;
         last = rxd_pin_i;
         if (st > 5)
            `CHK("pin", rxd_pin_i, rx_line_o)
      end
      // Reset in mid-run clears sticky flags and restores the registers
      rst_n_i <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      {txc, rxs, sfe, brk} = 4'h0;
      rchk(8'h04, exp_st());
      rchk(8'h06, 8'h00);
      rchk(8'h07, 8'h03);
      `CHK("rst_line", 1'b1, rx_line_o)
      end_sim();
   end
endmodule
